// file: common/ssp_pkg.sv
// Constants, types and decode helpers of the synchronous serial port
package ssp_pkg;

  // Register byte offsets
  localparam logic [7:0] SSP_ADR_CTRL = 8'h00;
  localparam logic [7:0] SSP_ADR_STAT = 8'h04;
  localparam logic [7:0] SSP_ADR_DLO = 8'h08;
  localparam logic [7:0] SSP_ADR_DHI = 8'h0C;
  localparam logic [7:0] SSP_ADR_IRQ = 8'h10;

  // Control register fields
  localparam int SSP_C_HI = 6;
  localparam int SSP_C_LO = 5;
  localparam int SSP_C_OD = 4;
  localparam int SSP_C_EXT = 3;
  localparam int SSP_C_PRE = 0;
  localparam int SSP_C_PRE_W = 3;

  // Status register fields; reserved ones read as the fixed pattern
  localparam int SSP_S_SOL = 6;
  localparam int SSP_S_OVR = 5;
  localparam int SSP_S_START = 0;
  localparam logic [7:0] SSP_STAT_RSVD = 8'h9C;

  // Interrupt register fields
  localparam int SSP_I_REQ = 0;
  localparam int SSP_I_EN = 1;

  // Word lengths in bits
  localparam logic [4:0] SSP_W8 = 5'h08;
  localparam logic [4:0] SSP_W16 = 5'h10;

  localparam logic [31:0] SSP_ZERO32 = 32'h0000_0000;

  typedef enum logic {SSP_IDLE = 1'b0, SSP_BUSY = 1'b1} ssp_state_t;

  typedef struct packed {
    logic mode_hi;
    logic mode_lo;
    logic open_drain;
    logic clock_source_select;
    logic [SSP_C_PRE_W-1:0] prescale;
  } ssp_ctrl_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe_n;
    logic so_o;
    logic so_oe_n;
  } ssp_pins_t;

  // Half period minus one, in system clocks, per prescale code
  function automatic logic [8:0] ssp_half_m1(input logic [2:0] sel);
    case (sel)
      3'h0: ssp_half_m1 = 9'h1FF;
      3'h1: ssp_half_m1 = 9'h07F;
      3'h2: ssp_half_m1 = 9'h01F;
      3'h3: ssp_half_m1 = 9'h00F;
      3'h4: ssp_half_m1 = 9'h007;
      3'h5: ssp_half_m1 = 9'h003;
      3'h6: ssp_half_m1 = 9'h001;
      default: ssp_half_m1 = 9'h000;
    endcase
  endfunction

endpackage

// file: rtl/ssp_core.sv
// Synchronous serial port with APB register slave
`timescale 1ns/100ps

module ssp_core
  import ssp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock_pin_i,
  input wire logic serial_in_pin_i,
  output ssp_pins_t serial_pins,
  output logic irq
);

  typedef struct packed {
    ssp_state_t state;
    ssp_ctrl_t ctrl;
    logic [15:0] dat;
    logic [4:0] cnt;
    logic [8:0] pre;
    logic sck;
    logic so;
    logic ovr;
    logic ovr_seen;
    logic done_seen;
    logic irq_req;
    logic irq_en;
    logic irq;
    logic sck_s1;
    logic sck_s2;
    logic sck_prev;
    logic si_s1;
    logic si_s2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    ssp_pins_t pins;
  } ssp_st_t;

  ssp_st_t st_r;
  ssp_st_t st_nxt;
  logic ext;
  logic cont;
  logic act;
  logic tick;
  logic fall_ev;
  logic rise_ev;
  logic done_now;
  logic ovr_now;
  logic acc;
  logic wr;
  logic [4:0] width;

  always_comb
  begin
    st_nxt = st_r;
    ext = st_r.ctrl.clock_source_select;
    cont = st_r.ctrl.mode_hi & ~st_r.ctrl.mode_lo & ~ext;
    act = (st_r.state == SSP_BUSY) | cont;
    width = st_r.ctrl.mode_lo ? SSP_W16 : SSP_W8;
    tick = 1'b0;
    done_now = 1'b0;
    ovr_now = 1'b0;
    // Pins are asynchronous to sys_clk
    st_nxt.sck_s1 = serial_clock_pin_i;
    st_nxt.sck_s2 = st_r.sck_s1;
    st_nxt.sck_prev = st_r.sck_s2;
    st_nxt.si_s1 = serial_in_pin_i;
    st_nxt.si_s2 = st_r.si_s1;

    if (act & ~ext)
    begin
      if (st_r.pre == ssp_half_m1(st_r.ctrl.prescale))
      begin
        st_nxt.pre = '0;
        st_nxt.sck = ~st_r.sck;
        tick = 1'b1;
      end
      else
        st_nxt.pre = st_r.pre + 9'h001;
    end
    else
    begin
      st_nxt.pre = '0;
      st_nxt.sck = 1'b1;
    end
    // External edges show up three clocks late; slow peers only
    fall_ev = ext ? (st_r.sck_prev & ~st_r.sck_s2) : (tick & st_r.sck);
    rise_ev = ext ? (~st_r.sck_prev & st_r.sck_s2) : (tick & ~st_r.sck);

    if (st_r.state == SSP_BUSY)
    begin
      if (fall_ev)
        st_nxt.so = st_r.dat[0];
      if (rise_ev)
      begin
        // Received bit enters at the top as sent bits leave the bottom
        if (st_r.ctrl.mode_lo)
          st_nxt.dat = {st_r.si_s2, st_r.dat[15:1]};
        else
          st_nxt.dat[7:0] = {st_r.si_s2, st_r.dat[7:1]};
        st_nxt.cnt = st_r.cnt + 5'h01;
        if (st_r.cnt == width - 5'h01)
        begin
          st_nxt.state = SSP_IDLE;
          done_now = 1'b1;
          st_nxt.done_seen = 1'b1;
        end
      end
    end
    // Once a word is done, a stray external pulse only flags overrun
    else if (ext & st_r.done_seen & rise_ev)
      ovr_now = 1'b1;
    if (ovr_now)
      st_nxt.ovr = 1'b1;
    if (done_now)
      st_nxt.irq_req = 1'b1;

    // One wait state: data is prepared in the first access cycle
    acc = psel & penable & ~st_r.pready;
    wr = psel & penable & st_r.pready & pwrite;
    st_nxt.pready = acc;
    st_nxt.pslverr = 1'b0;
    if (acc)
    begin
      st_nxt.prdata = SSP_ZERO32;
      unique case (paddr)
        SSP_ADR_CTRL: st_nxt.prdata[6:0] = st_r.ctrl;
        SSP_ADR_STAT:
        begin
          st_nxt.prdata[7:0] = SSP_STAT_RSVD;
          st_nxt.prdata[SSP_S_SOL] = st_r.so;
          st_nxt.prdata[SSP_S_OVR] = st_r.ovr;
          st_nxt.prdata[SSP_S_START] = (st_r.state == SSP_BUSY);
          if (~pwrite & st_r.ovr)
            st_nxt.ovr_seen = 1'b1;
        end
        SSP_ADR_DLO: st_nxt.prdata[7:0] = st_r.dat[7:0];
        SSP_ADR_DHI: st_nxt.prdata[7:0] = st_r.dat[15:8];
        SSP_ADR_IRQ:
        begin
          st_nxt.prdata[SSP_I_REQ] = st_r.irq_req;
          st_nxt.prdata[SSP_I_EN] = st_r.irq_en;
        end
        default: st_nxt.pslverr = 1'b1;
      endcase
    end

    if (wr)
    begin
      unique case (paddr)
        SSP_ADR_CTRL:
        begin
          st_nxt.ctrl = pwdata[6:0];
          st_nxt.state = SSP_IDLE;
          st_nxt.cnt = '0;
          st_nxt.pre = '0;
          st_nxt.sck = 1'b1;
        end
        SSP_ADR_STAT:
        begin
          // Level and start are ignored mid-transfer
          if (st_r.state == SSP_IDLE)
          begin
            st_nxt.so = pwdata[SSP_S_SOL];
            if (pwdata[SSP_S_START])
            begin
              st_nxt.state = SSP_BUSY;
              st_nxt.cnt = '0;
              st_nxt.pre = '0;
              st_nxt.done_seen = 1'b0;
            end
          end
          if (~pwdata[SSP_S_OVR] & st_r.ovr_seen & ~ovr_now)
          begin
            st_nxt.ovr = 1'b0;
            st_nxt.ovr_seen = 1'b0;
          end
        end
        SSP_ADR_DLO: st_nxt.dat[7:0] = pwdata[7:0];
        SSP_ADR_DHI: st_nxt.dat[15:8] = pwdata[7:0];
        SSP_ADR_IRQ:
        begin
          st_nxt.irq_req = (st_r.irq_req & pwdata[SSP_I_REQ]) | done_now;
          st_nxt.irq_en = pwdata[SSP_I_EN];
        end
        default: ;
      endcase
    end

    st_nxt.irq = st_r.irq_req & st_r.irq_en;
    st_nxt.pins.sck_o = st_nxt.sck;
    st_nxt.pins.sck_oe_n = st_nxt.ctrl.clock_source_select;
    st_nxt.pins.so_o = st_nxt.so;
    // Open drain releases the pin for a high level
    st_nxt.pins.so_oe_n = st_nxt.ctrl.open_drain & st_nxt.so;
  end

  // Reset parks the clock pin high, its idle level
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      st_r.sck <= 1'b1;
      st_r.pins.sck_o <= 1'b1;
    end
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign serial_pins = st_r.pins;
  assign irq = st_r.irq;

  default clocking cb @(posedge sys_clk iff clk_en);
  endclocking
  default disable iff (!rstn);

  AST_CTRL_RESET: assert property (wr && paddr == SSP_ADR_CTRL
    |=> st_r.state == SSP_IDLE && st_r.cnt == '0)
    else $error("control write did not reset transfer");
  AST_START_BUSY: assert property (wr && paddr == SSP_ADR_STAT
    && pwdata[SSP_S_START] && st_r.state == SSP_IDLE |=> st_r.state == SSP_BUSY)
    else $error("start did not begin transfer");
  AST_DONE_IRQ: assert property (st_r.state == SSP_BUSY
    && st_nxt.state == SSP_IDLE && !wr |=> st_r.irq_req)
    else $error("completion missed request flag");
  AST_IRQ_GATE: assert property (##1 irq == $past(st_r.irq_req && st_r.irq_en))
    else $error("interrupt output not gated by enable");
  AST_SO_FALL: assert property (st_r.state == SSP_BUSY
    && $past(st_r.state == SSP_BUSY)
    && $changed(st_r.so) |-> $past(fall_ev))
    else $error("output bit changed off falling edge");
  AST_IDLE_HIGH: assert property (!ext && !act && !$past(act)
    |-> st_r.sck && serial_pins.sck_o)
    else $error("internal clock not resting high");
  AST_OVR_SET: assert property (ovr_now |=> st_r.ovr && st_r.state == SSP_IDLE)
    else $error("late external pulse missed overrun");
  AST_CNT_MAX: assert property (st_r.cnt <= SSP_W16)
    else $error("bit counter beyond word length");
  AST_PRE_MAX: assert property (!ext |-> st_r.pre <= ssp_half_m1(st_r.ctrl.prescale))
    else $error("prescaler beyond selected ratio");
  AST_OE_DIR: assert property (##1 serial_pins.sck_oe_n == st_r.ctrl.clock_source_select)
    else $error("clock pin direction wrong");
  // A single ready pulse stops one access from being answered twice
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error response outside ready");
  AST_SO_HOLD: assert property (st_r.state == SSP_IDLE && !wr
    |=> $stable(st_r.so))
    else $error("output level moved while idle");
  AST_EXT_NO_SHIFT: assert property (ext && st_r.state == SSP_IDLE && !wr
    |=> $stable(st_r.dat))
    else $error("data shifted outside a transfer");
  // A start written mid-word must not restart the sequence
  AST_START_IGNORED: assert property (wr && paddr == SSP_ADR_STAT
    && st_r.state == SSP_BUSY && !done_now |=> st_r.state == SSP_BUSY)
    else $error("start write disturbed a running transfer");

  COV_DONE8: cover property (done_now && !st_r.ctrl.mode_lo);
  COV_DONE16: cover property (done_now && st_r.ctrl.mode_lo);
  COV_OVR: cover property (ovr_now);
  COV_CONT: cover property (cont && tick);
  COV_EXT_DONE: cover property (done_now && ext);

endmodule

// file: verification/ssp_peer.sv
// Behavioural external serial peer: sends a word, captures the port output
`timescale 1ns/100ps
module ssp_peer
(
  input wire logic sck,
  input wire logic so,
  input wire logic load,
  input wire logic [15:0] word,
  output logic si,
  output logic ext_sck,
  output logic [15:0] rx,
  output int idx
);
  initial
  begin
    si = 1'b0;
    ext_sck = 1'b1;
    rx = 16'h0000;
    idx = 0;
  end
  // Past the word the line toggles, so stale data cannot pass as a match
  always @(negedge sck or posedge load)
  begin
    if (load)
      idx <= 0;
    else
    begin
      si <= (idx < 16) ? word[idx] : ~si;
      idx <= idx + 1;
    end
  end
  always @(posedge sck)
    rx <= {so, rx[15:1]};
  // Phases far above the port's synchroniser delay; idle high
  task automatic burst(input int n);
    // Keep pin edges away from the rising edge of sys_clk
    #12.5;
    repeat (n)
    begin
      #200 ext_sck = 1'b0;
      #200 ext_sck = 1'b1;
    end
  endtask
endmodule

// file: verification/tb.sv
// Self-checking bench of the serial port: APB traffic and a serial peer
`timescale 1ns/100ps
module tb;
  import ssp_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = SSP_ZERO32;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic err;
  logic irq;
  logic load = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [15:0] rx;
  logic [31:0] rd;
  logic si;
  logic ext_sck;
  logic sck_w;
  logic so_w;
  int idx;
  int n_errors = 0;
  int tests_run = 0;
  ssp_pins_t pins;
  always #12.5 sys_clk = ~sys_clk;
  // Released open-drain output reads as pulled up
  assign so_w = pins.so_oe_n ? 1'b1 : pins.so_o;
  assign sck_w = pins.sck_oe_n ? ext_sck : pins.sck_o;
  ssp_core u_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_clock_pin_i(sck_w),
    .serial_in_pin_i(si), .serial_pins(pins), .irq(irq));
  ssp_peer u_peer (.sck(sck_w), .so(so_w), .load(load), .word(word), .si(si),
    .ext_sck(ext_sck), .rx(rx), .idx(idx));
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic start_peer(input logic [15:0] w);
    word <= w;
    load <= 1'b1;
    @(posedge sys_clk);
    load <= 1'b0;
    apb(1'b1, SSP_ADR_STAT, 32'h1);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do
    begin
      apb(1'b0, SSP_ADR_STAT, 32'h0);
      k++;
    end
    while (rd[0] !== 1'b0 && k < 300);
    chk("busy clear", {31'h0, rd[0]}, 32'h0);
  endtask
  task automatic t_reset();
    apb(1'b0, SSP_ADR_STAT, 32'h0);
    chk("stat reset", rd, 32'h9C);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, SSP_ADR_CTRL, 32'h10);
    apb(1'b1, SSP_ADR_STAT, 32'h40);
    @(posedge sys_clk);
    chk("so level", {31'h0, pins.so_o}, 32'h1);
    chk("od release", {31'h0, pins.so_oe_n}, 32'h1);
    apb(1'b0, SSP_ADR_STAT, 32'h0);
    chk("stat level", rd, 32'hDC);
    $display("reset test done");
  endtask
  task automatic xfer(input logic w16, input logic [15:0] tx, input logic [15:0] pw);
    int n;
    n = w16 ? 16 : 8;
    apb(1'b1, SSP_ADR_CTRL, {26'h0, w16, 5'h04});
    apb(1'b0, SSP_ADR_CTRL, 32'h0);
    chk("ctrl read", rd, {26'h0, w16, 5'h04});
    apb(1'b1, SSP_ADR_DLO, {24'h0, tx[7:0]});
    apb(1'b1, SSP_ADR_DHI, {24'h0, tx[15:8]});
    apb(1'b1, SSP_ADR_IRQ, 32'h2);
    start_peer(pw);
    wait_idle();
    chk("clock edges", idx, n);
    chk("peer rx", rx >> (16 - n), w16 ? tx : tx[7:0]);
    chk("so hold", {31'h0, so_w}, {31'h0, tx[n-1]});
    chk("sck idle", {31'h0, sck_w}, 32'h1);
    apb(1'b0, SSP_ADR_DLO, 32'h0);
    chk("rx low", rd, {24'h0, pw[7:0]});
    apb(1'b0, SSP_ADR_DHI, 32'h0);
    chk("rx high", rd, w16 ? {24'h0, pw[15:8]} : {24'h0, tx[15:8]});
    apb(1'b0, SSP_ADR_IRQ, 32'h0);
    chk("irq reg", rd, 32'h3);
    chk("irq pin", {31'h0, irq}, 32'h1);
    apb(1'b1, SSP_ADR_IRQ, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk("irq clear", {31'h0, irq}, 32'h0);
    $display("transfer test done");
  endtask
  task automatic t_ext();
    apb(1'b1, SSP_ADR_CTRL, 32'h08);
    apb(1'b1, SSP_ADR_DLO, 32'h3C);
    start_peer(16'hFF5A);
    u_peer.burst(8);
    wait_idle();
    chk("ext rx", {24'h0, rx[15:8]}, 32'h3C);
    u_peer.burst(1);
    repeat (4) @(posedge sys_clk);
    apb(1'b0, SSP_ADR_STAT, 32'h0);
    chk("overrun", {31'h0, rd[SSP_S_OVR]}, 32'h1);
    apb(1'b0, SSP_ADR_DLO, 32'h0);
    chk("no shift", rd, 32'h5A);
    apb(1'b1, SSP_ADR_STAT, 32'h0);
    apb(1'b0, SSP_ADR_STAT, 32'h0);
    chk("ovr clear", {31'h0, rd[SSP_S_OVR]}, 32'h0);
    $display("external clock test done");
  endtask
  task automatic t_cont();
    apb(1'b1, SSP_ADR_CTRL, 32'h47);
    start_peer(16'h0000);
    repeat (40) @(posedge sys_clk);
    chk("free clock", {31'h0, idx >= 18}, 32'h1);
    $display("continuous clock test done");
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    xfer(1'b0, 16'h00A5, 16'h003C);
    xfer(1'b1, 16'hC381, 16'h7E12);
    t_ext();
    t_cont();
    report_and_stop();
  end
endmodule
